// file: hw/scrb_pkg.sv
// constants and field layout of the serial configuration register bank
// Notes on behaviour
// R1 - a word is 16 bits: 14 data bits then 2 address bits
// R2 - no path exists to read any register back over the serial bus
// R3 - address 00 loads pll configuration, 01 loads channel frequency
// R4 - the last two bits are the address, decoded at enable rise
// R5 - with more than sixteen bits only the newest sixteen are loaded
// R6 - host shifts at least sixteen bits before raising enable
// R7 - every register bit clears to zero at reset, valid at once
// R8 - host writes zero into every reserved bit
// R9 - bit 2 of pll configuration inverts charge pump direction
// R10 - bit 3 of pll configuration selects reference divide 9 or 18
// R11 - bit 4 routes analog pin: power control or data filter output
// R12 - bit 6 suppresses fsk modulation while transmitting
// R13 - bit 11 removes clipping of the strength output
// R14 - bit 10 arms lockout latch forcing amplifier enable low, cleared by rx
// R15 - bit 8 makes transmit buffer follow amplifier enable
// R16 - bit 7 zero pulls analog pin low, one leaves it floating
// R17 - channel register bits 13..2 hold the 12-bit divide ratio
// R18 - nonzero analog probe field turns strength and analog pins to test
// R19 - nonzero digital probe field turns data and amplifier pins to test
// R20 - while enable low, shift data msb first on each link clock rise
// R21 - address 10 loads the test access register
package scrb_pkg;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 2;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_PLL = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_CHAN = 2'h1;
    localparam logic [ADDR_W-1:0] ADDR_TEST = 2'h2;
    localparam logic [WORD_W-1:0] REG_RESET = 16'h0000;
    localparam int PUMP_BIT = 2;
    localparam int REFDIV_BIT = 3;
    localparam int AFUNC_BIT = 4;
    localparam int CW_BIT = 6;
    localparam int PWRPIN_BIT = 7;
    localparam int GATING_BIT = 8;
    localparam int LOCKOUT_BIT = 10;
    localparam int CLIP_BIT = 11;
    localparam int CHQ_LSB = 2;
    localparam int CHQ_MSB = 13;
    localparam int CHQ_W = 12;
    localparam int ATM_LSB = 2;
    localparam int ATM_MSB = 4;
    localparam int DTM_LSB = 5;
    localparam int DTM_MSB = 7;
    localparam int PROBE_W = 3;
    localparam logic [PROBE_W-1:0] PROBE_OFF = 3'h0;
    localparam int DIV_W = 5;
    localparam logic [DIV_W-1:0] REF_DIV_LO = 5'h09;
    localparam logic [DIV_W-1:0] REF_DIV_HI = 5'h12;
endpackage

// file: hw/scrb_serial_config_register_bank.sv
// serial configuration register bank with three-wire write-only port
`timescale 1ns/1ps
module scrb_serial_config_register_bank (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic ser_clk_in,
    input wire logic ser_en_in,
    input wire logic ser_data_in,
    input wire logic receive_on_input_in,
    input wire logic transceiver_enable_input_in,
    input wire logic supply_low_in,
    input wire logic pa_request_in,
    input wire logic rx_data_in,
    input wire logic digital_probe_pa_in,
    input wire logic digital_probe_data_in,
    output logic pump_polarity_bit_out,
    output logic [scrb_pkg::DIV_W-1:0] ref_divide_ratio_out,
    output logic analog_pin_function_out,
    output logic unmodulated_carrier_bit_out,
    output logic fsk_mod_enable_out,
    output logic strength_clip_disable_out,
    output logic analog_pin_low_oe_out,
    output logic tx_buffer_on_out,
    output logic amplifier_enable_output_out,
    output logic data_out,
    output logic [scrb_pkg::CHQ_W-1:0] channel_divide_ratio_out,
    output logic [scrb_pkg::PROBE_W-1:0] analog_probe_select_out,
    output logic analog_test_active_out,
    output logic [scrb_pkg::PROBE_W-1:0] digital_probe_select_out,
    output logic short_word_out
);
    import scrb_pkg::*;

    // ---------------- link domain (serial clock) ----------------
    // reset reaches the link domain through two flops; the serial clock
    // may stand still, so nothing here depends on it for commit timing
    logic lrst_s1_reg;
    logic lrst_s2_reg;
    logic [WORD_W-1:0] shift_reg;
    logic [WORD_W-1:0] shift_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic tgl_s1_reg;
    logic tgl_s2_reg;
    logic tgl_seen_reg;
    logic commit_tgl_reg;
    logic new_frame;

    assign new_frame = tgl_s2_reg != tgl_seen_reg;
    // msb first: each bit enters at the bottom and pushes older ones up
    assign shift_next = {shift_reg[WORD_W-2:0], ser_data_in}; // R20 R5
    assign cnt_next = new_frame ? CNT_W'(1) :
        (cnt_reg == CNT_FULL) ? cnt_reg : cnt_reg + CNT_W'(1);

    always_ff @(posedge ser_clk_in) begin
        lrst_s1_reg <= srst_in;
        lrst_s2_reg <= lrst_s1_reg;
    end

    always_ff @(posedge ser_clk_in) begin
        tgl_s1_reg <= commit_tgl_reg;
        tgl_s2_reg <= tgl_s1_reg;
    end

    always_ff @(posedge ser_clk_in) begin
        if (lrst_s2_reg) begin
            shift_reg <= REG_RESET;
            cnt_reg <= '0;
            tgl_seen_reg <= 1'b0;
        end else if (!ser_en_in) begin // R20
            shift_reg <= shift_next;
            cnt_reg <= cnt_next;
            tgl_seen_reg <= tgl_s2_reg;
        end
    end

    // ---------------- system domain ----------------
    logic en_s1_reg;
    logic en_s2_reg;
    logic en_s3_reg;
    logic rx_s1_reg;
    logic rx_s2_reg;
    logic rx_s3_reg;
    logic xc_s1_reg;
    logic xc_s2_reg;
    logic lv_s1_reg;
    logic lv_s2_reg;

    always_ff @(posedge clk_sys_in) begin
        en_s1_reg <= ser_en_in;
        en_s2_reg <= en_s1_reg;
        rx_s1_reg <= receive_on_input_in;
        rx_s2_reg <= rx_s1_reg;
        xc_s1_reg <= transceiver_enable_input_in;
        xc_s2_reg <= xc_s1_reg;
        lv_s1_reg <= supply_low_in;
        lv_s2_reg <= lv_s1_reg;
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            en_s3_reg <= 1'b1;
            rx_s3_reg <= 1'b0;
        end else begin
            en_s3_reg <= en_s2_reg;
            rx_s3_reg <= rx_s2_reg;
        end
    end

    // the shift word is frozen while enable is high, so it is safe to
    // sample once the synchronised rising edge is seen
    logic en_rise;
    logic full_word;
    logic commit;
    logic [ADDR_W-1:0] word_addr;
    logic hit_pll;
    logic hit_chan;
    logic hit_test;

    assign en_rise = en_s2_reg && !en_s3_reg;
    assign full_word = cnt_reg == CNT_FULL; // R6
    // a short word is dropped rather than loading unpredictable bits
    assign commit = en_rise && full_word;
    assign word_addr = shift_reg[ADDR_W-1:0]; // R4 R1
    assign hit_pll = commit && word_addr == ADDR_PLL; // R3
    assign hit_chan = commit && word_addr == ADDR_CHAN; // R3
    assign hit_test = commit && word_addr == ADDR_TEST; // R21

    logic [WORD_W-1:0] pll_reg;
    logic [WORD_W-1:0] chan_reg;
    logic [WORD_W-1:0] test_reg;
    logic short_reg;

    // the registers have no read path at all; only decoded fields leave
    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin // R7
            pll_reg <= REG_RESET;
            chan_reg <= REG_RESET;
            test_reg <= REG_RESET;
        end else begin // R2
            if (hit_pll) pll_reg <= shift_reg; // R4
            if (hit_chan) chan_reg <= shift_reg; // R4
            if (hit_test) test_reg <= shift_reg; // R4
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            commit_tgl_reg <= 1'b0;
            short_reg <= 1'b0;
        end else if (en_rise) begin
            commit_tgl_reg <= !commit_tgl_reg;
            short_reg <= !full_word;
        end
    end

    // ---------------- field decode ----------------
    logic [PROBE_W-1:0] analog_probe_select;
    logic [PROBE_W-1:0] digital_probe_select;
    logic atm_on;
    logic dtm_on;
    logic tx_active;
    logic rx_fall;

    assign analog_probe_select = test_reg[ATM_MSB:ATM_LSB];
    assign digital_probe_select = test_reg[DTM_MSB:DTM_LSB];
    assign atm_on = analog_probe_select != PROBE_OFF; // R18
    assign dtm_on = digital_probe_select != PROBE_OFF; // R19
    assign tx_active = xc_s2_reg && !rx_s2_reg;
    assign rx_fall = rx_s3_reg && !rx_s2_reg;

    logic lock_reg;
    logic lock_next;
    logic pin_state_reg;
    logic pa_reg;
    logic dout_reg;
    logic pa_next;
    logic dout_next;

    // rx high wins: it both clears and holds the latch open
    assign lock_next = rx_s2_reg ? 1'b0 :
        (pll_reg[LOCKOUT_BIT] && lv_s2_reg) ? 1'b1 : lock_reg; // R14
    assign pa_next = dtm_on ? digital_probe_pa_in :
        (pa_request_in && !lock_reg); // R19 R14
    assign dout_next = dtm_on ? digital_probe_data_in : rx_data_in; // R19

    always_ff @(posedge clk_sys_in) begin
        if (srst_in) begin
            lock_reg <= 1'b0;
            pin_state_reg <= 1'b0;
            pa_reg <= 1'b0;
            dout_reg <= 1'b0;
        end else begin
            lock_reg <= lock_next;
            pa_reg <= pa_next;
            dout_reg <= dout_next;
            // pin only changes at the start of a transmit slot
            if (rx_fall) pin_state_reg <= pll_reg[PWRPIN_BIT]; // R16
        end
    end

    assign pump_polarity_bit_out = pll_reg[PUMP_BIT]; // R9
    assign ref_divide_ratio_out =
        pll_reg[REFDIV_BIT] ? REF_DIV_HI : REF_DIV_LO; // R10
    assign analog_pin_function_out = pll_reg[AFUNC_BIT]; // R11
    assign unmodulated_carrier_bit_out = pll_reg[CW_BIT];
    assign fsk_mod_enable_out =
        !(pll_reg[CW_BIT] && tx_active); // R12
    assign strength_clip_disable_out = pll_reg[CLIP_BIT]; // R13
    // zero in the pin state bit pulls the open-drain pin to ground while bit 4 and the analog probe field are both zero
    assign analog_pin_low_oe_out = !atm_on && !pll_reg[AFUNC_BIT] &&
        !pin_state_reg; // R16 R11 R18
    assign tx_buffer_on_out = tx_active &&
        (!pll_reg[GATING_BIT] || pa_reg); // R15
    assign amplifier_enable_output_out = pa_reg;
    assign data_out = dout_reg;
    assign channel_divide_ratio_out = chan_reg[CHQ_MSB:CHQ_LSB]; // R17
    assign analog_probe_select_out = analog_probe_select;
    assign analog_test_active_out = atm_on; // R18
    assign digital_probe_select_out = digital_probe_select;
    assign short_word_out = short_reg;

    // ---------------- assertions ----------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (srst_in);

    a_pll_load: assert property ( // R3
        hit_pll |=> pll_reg == $past(shift_reg))
        else $error("pll word not loaded");
    a_chan_load: assert property ( // R17
        hit_chan |=> channel_divide_ratio_out ==
            $past(shift_reg[CHQ_MSB:CHQ_LSB]))
        else $error("channel ratio not loaded");
    a_test_load: assert property ( // R21
        hit_test |=> test_reg == $past(shift_reg))
        else $error("test word not loaded");
    a_only_addressed: assert property ( // R4
        (en_rise && word_addr != ADDR_PLL) |=> $stable(pll_reg))
        else $error("pll register hit by other address");
    a_hold_idle: assert property ( // R2
        !en_rise |=> $stable(chan_reg) && $stable(test_reg))
        else $error("register changed without commit");
    a_reset_zero: assert property ( // R7
        @(posedge clk_sys_in) disable iff (1'b0)
        srst_in |=> pll_reg == REG_RESET && chan_reg == REG_RESET &&
            test_reg == REG_RESET)
        else $error("registers not cleared by reset");
    a_ref_divide: assert property ( // R10
        hit_pll |=> ref_divide_ratio_out ==
            ($past(shift_reg[REFDIV_BIT]) ? REF_DIV_HI : REF_DIV_LO))
        else $error("reference divide wrong");
    a_lockout_pa: assert property ( // R14
        (lock_reg && !dtm_on) |=> !amplifier_enable_output_out)
        else $error("amplifier enabled during lockout");
    a_lockout_set: assert property ( // R14
        (pll_reg[LOCKOUT_BIT] && lv_s2_reg && !rx_s2_reg) |=> lock_reg)
        else $error("lockout latch not set");
    a_probe_data: assert property ( // R19
        dtm_on |=> data_out == $past(digital_probe_data_in))
        else $error("digital probe not routed");
    a_cw_mod: assert property ( // R12
        (pll_reg[CW_BIT] && tx_active) |-> !fsk_mod_enable_out)
        else $error("modulation during carrier test");

    // each pll field must land with the committed word, not a stale one

    a_pump_load: assert property ( // R9
        hit_pll |=> pump_polarity_bit_out == $past(shift_reg[PUMP_BIT]))
        else $error("pump polarity not loaded");

    a_afunc_load: assert property ( // R11
        hit_pll |=> analog_pin_function_out ==
            $past(shift_reg[AFUNC_BIT]))
        else $error("analog pin function not loaded");

    a_unmod_load: assert property ( // R12
        hit_pll |=> unmodulated_carrier_bit_out ==
            $past(shift_reg[CW_BIT]))
        else $error("carrier test bit not loaded");

    a_clip_load: assert property ( // R13
        hit_pll |=> strength_clip_disable_out ==
            $past(shift_reg[CLIP_BIT]))
        else $error("clip disable not loaded");

    // a short word must leave every register untouched and raise the flag

    a_short_drop: assert property ( // R6
        (en_rise && !full_word) |=>
            $stable(pll_reg) && $stable(chan_reg) && $stable(test_reg))
        else $error("short word changed a register");

    a_short_flag: assert property ( // R6
        en_rise |=> short_word_out == !$past(full_word))
        else $error("short word flag wrong");

    a_chan_hold: assert property ( // R4
        (en_rise && word_addr != ADDR_CHAN) |=> $stable(chan_reg))
        else $error("channel register hit by other address");

    a_test_hold: assert property ( // R4
        (en_rise && word_addr != ADDR_TEST) |=> $stable(test_reg))
        else $error("test register hit by other address");

    a_probe_field: assert property ( // R18
        hit_test |=> analog_probe_select_out ==
            $past(shift_reg[ATM_MSB:ATM_LSB]))
        else $error("analog probe field not loaded");

    // receive-on high must release the latch even with the supply low

    a_lockout_clear: assert property ( // R14
        rx_s2_reg |=> !lock_reg)
        else $error("lockout latch not cleared by receive");

    a_probe_pa: assert property ( // R19
        dtm_on |=> amplifier_enable_output_out ==
            $past(digital_probe_pa_in))
        else $error("probe not routed to amplifier pin");

    a_rx_data: assert property ( // R19
        !dtm_on |=> data_out == $past(rx_data_in))
        else $error("receive data not routed");

    // buffer gating is combinational, so these hold in the same cycle

    a_buffer_gated: assert property ( // R15
        (tx_active && pll_reg[GATING_BIT] && !pa_reg) |->
            !tx_buffer_on_out)
        else $error("buffer on without amplifier");

    a_buffer_on: assert property ( // R15
        (tx_active && !pll_reg[GATING_BIT]) |-> tx_buffer_on_out)
        else $error("buffer off during transmit");

    a_fsk_idle: assert property ( // R12
        !tx_active |-> fsk_mod_enable_out)
        else $error("modulation suppressed outside transmit");

    a_probe_pin: assert property ( // R18
        atm_on |-> !analog_pin_low_oe_out)
        else $error("pin pulled low during analog probe");

    // the pin state only moves at the start of a transmit slot

    a_pin_latch: assert property ( // R16
        !rx_fall |=> $stable(pin_state_reg))
        else $error("pin state moved outside receive fall");

    a_pin_follow: assert property ( // R16
        rx_fall |=> pin_state_reg == $past(pll_reg[PWRPIN_BIT]))
        else $error("pin state not latched at receive fall");

    c_pll_write: cover property (hit_pll);
    c_chan_write: cover property (hit_chan);
    c_test_write: cover property (hit_test);
    c_short_word: cover property (en_rise && !full_word);
    c_lockout_hit: cover property (lock_reg && pa_request_in);
endmodule

// file: verification/scrb_host_model.sv
// host model driving the three-wire configuration bus
`timescale 1ns/1ps
module scrb_host_model (
    output logic ser_clk_out,
    output logic ser_en_out,
    output logic ser_data_out
);
    initial begin
        ser_clk_out = 1'b0;
        ser_en_out = 1'b1;
        ser_data_out = 1'b0;
    end
    task automatic pulse();
        #6 ser_clk_out = 1'b1;
        #6 ser_clk_out = 1'b0;
    endtask
    // idle clocks with enable high let the bit counter restart
    task automatic open_frame();
        repeat (3) pulse();
        ser_en_out = 1'b0;
    endtask
    task automatic put_bit(input logic b);
        ser_data_out = b;
        pulse();
    endtask
    task automatic shift16(input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            put_bit(w[i]);
        end
    endtask
    task automatic close_frame();
        #12 ser_en_out = 1'b1;
        // a released data line must not keep showing the last bit
        ser_data_out = ~ser_data_out;
        #120;
    endtask
    task automatic send_word(input logic [15:0] w);
        open_frame();
        shift16(w);
        close_frame();
    endtask
endmodule

// file: verification/test_serial_config_register_bank.sv
// self-checking bench for the serial configuration register bank
`timescale 1ns/1ps
module test_serial_config_register_bank;
    import scrb_pkg::*;
    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic rx_on = 1'b1, transceiver_enable_input = 1'b0, sup_low = 1'b0, pa_req = 1'b0;
    logic rx_d = 1'b0, pr_pa = 1'b0, pr_d = 1'b0;
    wire ser_clk, ser_en, ser_d;
    wire pump, afunc, cw, fsk, clip, pin_oe, buf_on, amp, dout, aon, shortw;
    wire [DIV_W-1:0] rdiv;
    wire [CHQ_W-1:0] channel_divide_ratio;
    wire [PROBE_W-1:0] analog_probe_select, digital_probe_select;
    int error_cnt = 0;
    int compares = 0;
    always #10 clk_sys_in = ~clk_sys_in;
    scrb_host_model host (.ser_clk_out(ser_clk), .ser_en_out(ser_en),
        .ser_data_out(ser_d));
    scrb_serial_config_register_bank DUT (.clk_sys_in(clk_sys_in),
        .srst_in(srst_in), .ser_clk_in(ser_clk), .ser_en_in(ser_en),
        .ser_data_in(ser_d), .receive_on_input_in(rx_on),
        .transceiver_enable_input_in(transceiver_enable_input), .supply_low_in(sup_low),
        .pa_request_in(pa_req), .rx_data_in(rx_d),
        .digital_probe_pa_in(pr_pa), .digital_probe_data_in(pr_d),
        .pump_polarity_bit_out(pump), .ref_divide_ratio_out(rdiv),
        .analog_pin_function_out(afunc), .unmodulated_carrier_bit_out(cw),
        .fsk_mod_enable_out(fsk), .strength_clip_disable_out(clip),
        .analog_pin_low_oe_out(pin_oe), .tx_buffer_on_out(buf_on),
        .amplifier_enable_output_out(amp), .data_out(dout),
        .channel_divide_ratio_out(channel_divide_ratio), .analog_probe_select_out(analog_probe_select),
        .analog_test_active_out(aon), .digital_probe_select_out(digital_probe_select),
        .short_word_out(shortw));
    task automatic check(input logic [15:0] got, input logic [15:0] exp,
            input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time,
                what, got, exp);
        end
    endtask
    // covers the two-stage sync plus the output flop
    task automatic settle();
        repeat (6) @(posedge clk_sys_in);
    endtask
    task automatic wr(input logic [15:0] w);
        host.send_word(w);
        repeat (2) @(posedge clk_sys_in);
    endtask
    task automatic t_reset();
        check(rdiv, REF_DIV_LO, "ref div");
        check(fsk, 1'b1, "fsk");
        check(pin_oe, 1'b1, "pin pull");
        check({pump, afunc, cw, clip, shortw, amp}, 0, "pll bits");
        check(channel_divide_ratio, 0, "chan");
        check({analog_probe_select, digital_probe_select, aon}, 0, "test");
        $display("t_reset done");
    endtask
    task automatic t_pll();
        wr(16'h0D5C);
        check({pump, afunc, cw, clip}, 4'hF, "pll bits");
        check(rdiv, REF_DIV_HI, "ref div");
        check({pin_oe, channel_divide_ratio}, 0, "pin chan");
        @(posedge clk_sys_in);
        transceiver_enable_input <= 1'b1;
        rx_on <= 1'b0;
        settle();
        check({fsk, buf_on}, 0, "no mod no pa");
        pa_req <= 1'b1;
        settle();
        check({amp, buf_on}, 2'h3, "pa on");
        sup_low <= 1'b1;
        settle();
        check({amp, buf_on}, 0, "lockout");
        rx_on <= 1'b1;
        settle();
        check(amp, 1'b1, "lockout cleared");
        sup_low <= 1'b0;
        rx_on <= 1'b0;
        pa_req <= 1'b0;
        wr(16'h0080);
        check({fsk, pin_oe}, 2'h3, "pin before edge");
        check({buf_on, amp}, 2'h2, "buffer ungated");
        rx_on <= 1'b1;
        settle();
        rx_on <= 1'b0;
        settle();
        check(pin_oe, 1'b0, "pin released");
        $display("t_pll done");
    endtask
    task automatic t_chan();
        host.open_frame();
        repeat (4) host.put_bit(1'b1);
        host.shift16(16'h2AF1);
        host.close_frame();
        repeat (2) @(posedge clk_sys_in);
        check(channel_divide_ratio, 12'hABC, "chan");
        check({pump, pin_oe, rdiv}, REF_DIV_LO, "pll kept");
        $display("t_chan done");
    endtask
    task automatic t_test();
        pr_pa <= 1'b1;
        pr_d <= 1'b1;
        for (int k = 1; k < 8; k++) begin
            wr({8'h00, 3'(k), 3'(k), 2'b10});
            check({aon, analog_probe_select, digital_probe_select}, {1'b1, 3'(k), 3'(k)}, "probe");
            check({amp, dout}, 2'h3, "probe pins");
        end
        wr(16'hFFFF);
        check({analog_probe_select, channel_divide_ratio}, {3'h7, 12'hABC}, "addr 11");
        check(pump, 1'b0, "addr 11 pll");
        rx_d <= 1'b1;
        wr(16'h0002);
        check({aon, digital_probe_select, dout, amp}, 6'h02, "probe off");
        $display("t_test done");
    endtask
    task automatic t_short();
        host.open_frame();
        for (int i = 9; i >= 0; i--) begin
            host.put_bit(i == 0 || i == 2);
        end
        host.close_frame();
        repeat (2) @(posedge clk_sys_in);
        check({shortw, channel_divide_ratio}, {1'b1, 12'hABC}, "short word");
        $display("t_short done");
    endtask
    // reset in mid-run, with the link clock pulsed so its side resets too
    task automatic t_midreset();
        srst_in <= 1'b1;
        fork
            repeat (5) host.pulse();
            repeat (16) @(posedge clk_sys_in);
        join
        srst_in <= 1'b0;
        settle();
        check(channel_divide_ratio, 0, "chan after reset");
        check({pump, afunc, cw, clip, shortw, rdiv}, REF_DIV_LO, "pll");
        check({analog_probe_select, digital_probe_select, pin_oe}, 1, "test after reset");
        wr(16'h0008);
        check({rdiv, shortw}, {REF_DIV_HI, 1'b0}, "after reset");
        $display("t_midreset done");
    endtask
    task automatic final_report();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        // link side resets through its own clock, alongside the 16 cycles
        fork
            repeat (5) host.pulse();
            repeat (16) @(posedge clk_sys_in);
        join
        srst_in <= 1'b0;
        settle();
        t_reset();
        t_pll();
        t_chan();
        t_test();
        t_short();
        t_midreset();
        final_report();
    end
    initial begin
        #100000;
        error_cnt++;
        $display("wrong value at %0t: watchdog", $time);
        final_report();
    end
endmodule
